/* hdl/adcrf_top.sv */
// Purpose: format finished conversions into the result byte pair
// Assumes: core delivers a signed raw difference scaled 1024/vref
// Notes:   core signals share pclk, no synchroniser needed
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/10ps
module adcrf_top #(
    parameter int RAW_W = adcrf_pkg::ADCRF_RAW_W
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic              conv_done,
    input  wire logic signed [RAW_W-1:0] conv_raw,
    output logic [5:0]             channel_gain_field,
    output logic [1:0]             reference_select_field,
    output logic                   int_ref_enable,
    output logic                   temp_sensor_enable
);
    typedef struct packed {
        logic [7:0]  insel;
        logic        bipolar_input_select;
        logic        done;
        logic [9:0]  res;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
        logic        tsen;
        logic        iref;
    } adcrf_state_type;

    adcrf_state_type st_r, st_nxt;

    localparam int SW = RAW_W + 6;

    // signed limits keep every compare signed; an unsigned limit would
    // turn a negative difference into a huge positive one
    localparam logic signed [SW-1:0] UNI_MAX_S =
        SW'(adcrf_pkg::ADCRF_UNI_MAX);
    localparam logic signed [SW-1:0] BIP_MAX_S =
        SW'(adcrf_pkg::ADCRF_BIP_MAX);
    localparam logic signed [SW-1:0] BIP_MIN_S =
        SW'($signed(adcrf_pkg::ADCRF_BIP_MIN));
    localparam logic signed [SW-1:0] GAIN_S    =
        SW'(adcrf_pkg::ADCRF_GAIN_HI);

    function automatic logic is_diff(input logic [5:0] ch);
        is_diff = (ch >= adcrf_pkg::ADCRF_CH_DIFF_LO &&
                   ch <= adcrf_pkg::ADCRF_CH_DIFF_HI) ||
                  (ch >= adcrf_pkg::ADCRF_CH_RDIFF_LO);
    endfunction : is_diff

    // gain stage: 1x passes the difference, high gain multiplies it
    function automatic logic signed [SW-1:0] apply_gain(
        input logic signed [RAW_W-1:0] raw,
        input logic                    hi_gain
    );
        logic signed [SW-1:0] wide;
        wide = SW'(raw);
        if (hi_gain)
            apply_gain = wide * GAIN_S;
        else
            apply_gain = wide;
    endfunction : apply_gain

    // one-sided form: below zero clamps to 0, above full scale to top
    function automatic logic [9:0] sat_uni(
        input logic signed [SW-1:0] x
    );
        if (x[SW-1])
            sat_uni = '0;
        else if (x > UNI_MAX_S)
            sat_uni = adcrf_pkg::ADCRF_UNI_MAX;
        else
            sat_uni = x[9:0];
    endfunction : sat_uni

    // two's complement at half the unipolar scale, sign lands in bit 9
    function automatic logic [9:0] sat_bip(
        input logic signed [SW-1:0] x
    );
        logic signed [SW-1:0] half;
        half = x >>> 1;
        if (half > BIP_MAX_S)
            sat_bip = adcrf_pkg::ADCRF_BIP_MAX;
        else if (half < BIP_MIN_S)
            sat_bip = adcrf_pkg::ADCRF_BIP_MIN;
        else
            sat_bip = half[9:0];
    endfunction : sat_bip

    // set wins: a conversion ending in the clearing cycle stays visible
    function automatic logic next_done(
        input logic cur,
        input logic set,
        input logic clr
    );
        if (set)
            next_done = 1'b1;
        else if (clr)
            next_done = 1'b0;
        else
            next_done = cur;
    endfunction : next_done

    // read decode; unmapped offsets answer with an error and zero data
    function automatic logic [32:0] read_word(
        input logic [7:0]      addr,
        input adcrf_state_type s
    );
        logic [32:0] w;
        w = '0;
        unique case (addr)
            adcrf_pkg::ADCRF_OFS_INSEL:
                w[7:0] = s.insel;
            adcrf_pkg::ADCRF_OFS_CTRLB:
                w[adcrf_pkg::ADCRF_BIN_POS] = s.bipolar_input_select;
            adcrf_pkg::ADCRF_OFS_STATUS:
                w[adcrf_pkg::ADCRF_DONE_POS] = s.done;
            adcrf_pkg::ADCRF_OFS_RES_LO:
                w[7:0] = s.res[7:0];
            adcrf_pkg::ADCRF_OFS_RES_HI:
                w[1:0] = s.res[9:8];
            default:
                w[32] = 1'b1;
        endcase
        read_word = w;
    endfunction : read_word

    function automatic logic sel_temp(input logic [7:0] insel);
        sel_temp = insel[5:0] == adcrf_pkg::ADCRF_CH_TEMP;
    endfunction : sel_temp

    function automatic logic sel_int_ref(input logic [7:0] insel);
        sel_int_ref = insel[7:6] == adcrf_pkg::ADCRF_REFS_INT11;
    endfunction : sel_int_ref

    logic [5:0]                  ch;
    logic signed [SW-1:0]        scaled;
    logic [9:0]                  fmt;
    logic                        acc;
    logic                        wr_clr;

    always_comb begin
        ch     = st_r.insel[5:0];
        scaled = apply_gain(conv_raw, ch[0] && is_diff(ch));
        if (!is_diff(ch))
            fmt = sat_uni(scaled);
        else if (!st_r.bipolar_input_select)
            fmt = sat_uni(scaled);
        else
            fmt = sat_bip(scaled);
    end

    always_comb begin
        st_nxt         = st_r;
        st_nxt.pready  = 1'b0;
        st_nxt.pslverr = 1'b0;
        acc    = psel && penable && !st_r.pready;
        wr_clr = acc && pwrite &&
                 paddr == adcrf_pkg::ADCRF_OFS_STATUS &&
                 pwdata[adcrf_pkg::ADCRF_DONE_POS];
        // result and flag land in the same edge
        if (conv_done)
            st_nxt.res = fmt;
        st_nxt.done = next_done(st_r.done, conv_done, wr_clr);
        if (acc) begin
            st_nxt.pready = 1'b1;
            {st_nxt.pslverr, st_nxt.prdata} = read_word(paddr, st_r);
            if (pwrite && paddr == adcrf_pkg::ADCRF_OFS_INSEL)
                st_nxt.insel = pwdata[7:0];
            if (pwrite && paddr == adcrf_pkg::ADCRF_OFS_CTRLB)
                st_nxt.bipolar_input_select = pwdata[adcrf_pkg::ADCRF_BIN_POS];
        end
        st_nxt.tsen = sel_temp(st_nxt.insel);
        st_nxt.iref = sel_int_ref(st_nxt.insel);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pready                 = st_r.pready;
    assign prdata                 = st_r.prdata;
    assign pslverr                = st_r.pslverr;
    assign channel_gain_field     = st_r.insel[5:0];
    assign reference_select_field = st_r.insel[7:6];
    assign int_ref_enable         = st_r.iref;
    assign temp_sensor_enable     = st_r.tsen;
endmodule : adcrf_top

/* pkg/adcrf_pkg.sv */
// Purpose: constants for the converter result formatter
// Assumes: apb slave, 32-bit data, one register per aligned word
// Notes:   register offsets are byte addresses
package adcrf_pkg;
    localparam int          ADCRF_RES_W        = 10;
    localparam int          ADCRF_RAW_W        = 16;
    localparam logic [7:0]  ADCRF_OFS_INSEL    = 8'h00;
    localparam logic [7:0]  ADCRF_OFS_CTRLB    = 8'h04;
    localparam logic [7:0]  ADCRF_OFS_STATUS   = 8'h08;
    localparam logic [7:0]  ADCRF_OFS_RES_LO   = 8'h0c;
    localparam logic [7:0]  ADCRF_OFS_RES_HI   = 8'h10;
    localparam logic [7:0]  ADCRF_INSEL_RST    = 8'h00;
    localparam int          ADCRF_REFS_POS     = 6;
    localparam int          ADCRF_BIN_POS      = 7;
    localparam int          ADCRF_DONE_POS     = 0;
    localparam logic [1:0]  ADCRF_REFS_INT11   = 2'h2;
    localparam logic [5:0]  ADCRF_CH_TEMP      = 6'h22;
    localparam logic [5:0]  ADCRF_CH_DIFF_LO   = 6'h08;
    localparam logic [5:0]  ADCRF_CH_DIFF_HI   = 6'h1f;
    localparam logic [5:0]  ADCRF_CH_RDIFF_LO  = 6'h23;
    localparam logic [9:0]  ADCRF_UNI_MAX      = 10'h3ff;
    localparam logic [9:0]  ADCRF_BIP_MAX      = 10'h1ff;
    localparam logic [9:0]  ADCRF_BIP_MIN      = 10'h200;
    localparam logic [4:0]  ADCRF_GAIN_HI      = 5'h14;
endpackage : adcrf_pkg

/* testbench/adcrf_chk.sv */
// Purpose: port checks for the result formatter
// Assumes: bound to adcrf_top
// Notes: single clock domain
`timescale 1ns/10ps
module adcrf_chk #(parameter int RAW_W = 16) (
    input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic conv_done, int_ref_enable, temp_sensor_enable,
    input wire logic signed [RAW_W-1:0] conv_raw,
    input wire logic [5:0] channel_gain_field,
    input wire logic [1:0] reference_select_field
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd = pready && !pwrite;
    AST_TEMP: assert property (temp_sensor_enable ==
        (channel_gain_field == 6'h22)) else $error("temp enable");
    AST_IREF: assert property (int_ref_enable ==
        (reference_select_field == 2'h2)) else $error("ref enable");
    AST_ANS: assert property (psel && penable && !pready |=> pready)
        else $error("no answer");
    AST_ONE: assert property (pready |=> !pready) else $error("long ready");
    AST_ERR: assert property (pready |->
        pslverr == (paddr > 8'h10 || paddr[1:0] != 2'h0)) else $error("err");
    AST_LO: assert property (rd && paddr == 8'h0c |->
        prdata[31:8] == 24'h0) else $error("low byte");
    AST_HI: assert property (rd && paddr == 8'h10 |->
        prdata[31:2] == 30'h0) else $error("high byte");
    AST_SEL: assert property (rd && paddr == 8'h00 |-> prdata ==
        {24'h0, reference_select_field, channel_gain_field}) else $error("sel");
endmodule : adcrf_chk
bind adcrf_top adcrf_chk #(.RAW_W(RAW_W)) u_adcrf_chk (.*);

/* testbench/adcrf_core_model.sv */
// Purpose: converter core stand-in
// Assumes: go pulse starts one conversion
// Notes: raw toggles outside the done pulse
`timescale 1ns/10ps
module adcrf_core_model (
    input wire logic pclk, go,
    input wire logic signed [15:0] val,
    input wire logic [3:0] dly,
    output logic conv_done = 1'b0,
    output logic signed [15:0] conv_raw = 16'h0
);
    logic [3:0] cnt_r = 4'h0;
    logic busy_r = 1'b0;
    always @(posedge pclk) begin
        conv_done <= 1'b0;
        conv_raw <= ~conv_raw;
        if (go) begin busy_r <= 1'b1; cnt_r <= dly; end
        else if (busy_r && cnt_r == 4'h0) begin
            busy_r <= 1'b0; conv_done <= 1'b1; conv_raw <= val; end
        else cnt_r <= cnt_r - 4'h1;
    end
endmodule : adcrf_core_model

/* testbench/tb.sv */
// Purpose: self-checking bench for the result formatter
// Assumes: apb master, core model on the far side
// Notes: expectations queued by the driver
`timescale 1ns/10ps
module tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, conv_done, int_ref_enable, temp_sensor_enable;
    logic signed [15:0] conv_raw, val = 16'h0;
    logic [5:0] channel_gain_field, tbl[4] = '{6'h03, 6'h22, 6'h08, 6'h09};
    logic [1:0] reference_select_field;
    logic [3:0] dly = 4'h0;
    logic [15:0] rnd = 16'h844b;
    logic [32:0] exq[$];
    logic [9:0] v;
    int err_count = 0, checks = 0;
    always #4 pclk = ~pclk;
    adcrf_top u_adcrf_top (.*);
    adcrf_core_model u_adcrf_core_model (.*);
    task automatic report_and_stop;
        if (err_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic cmp(string n, logic [32:0] e, logic [32:0] s);
        checks++;
        if (e !== s) begin
            err_count++;
            $display("mismatch %s exp %h got %h", n, e, s);
        end
    endtask : cmp
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [32:0] e);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        if (!w) exq.push_back(e);
        @(posedge pclk) penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic conv(logic signed [15:0] r, logic [3:0] d);
        go <= 1'b1; val <= r; dly <= d;
        @(posedge pclk) go <= 1'b0;
        while (conv_done !== 1'b1) @(posedge pclk);
    endtask : conv
    function automatic logic [9:0] fmt(logic [5:0] c, logic b, int r);
        logic d;
        int x;
        d = (c >= 6'h08 && c <= 6'h1f) || c >= 6'h23;
        x = (d && c[0]) ? r * 20 : r;
        if (d && b) x = (x >>> 1) < -512 ? -512 : ((x >>> 1) > 511 ? 511 : x >>> 1);
        else x = x < 0 ? 0 : (x > 1023 ? 1023 : x);
        return x[9:0];
    endfunction : fmt
    always @(posedge pclk)
        if (pready === 1'b1 && pwrite === 1'b0)
            cmp("prdata", exq.pop_front(), {pslverr, prdata});
    initial begin
        #300000 err_count++;
        report_and_stop;
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 8'h00, 0, 33'h0);
        apb(0, 8'h04, 0, 33'h0);
        apb(0, 8'h14, 0, {1'b1, 32'h0});
        for (int i = 0; i < 16; i++) begin
            rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
            apb(1, 8'h00, {24'h0, 2'h2, tbl[i%4]}, 0);
            apb(1, 8'h04, {24'h0, i[2], 7'h0}, 0);
            conv($signed(rnd) >>> 4, i[1:0]);
            v = fmt(tbl[i%4], i[2], $signed(rnd) >>> 4);
            apb(0, 8'h08, 0, 33'h1);
            apb(0, 8'h0c, 0, {25'h0, v[7:0]});
            apb(0, 8'h10, 0, {31'h0, v[9:8]});
            apb(1, 8'h08, 1, 0);
            apb(0, 8'h0c, 0, {25'h0, v[7:0]});
        end
        @(posedge pclk);
        report_and_stop;
    end
endmodule : tb
